// *** hdl/serirq_consts.svh ***
`ifndef SERIRQ_CONSTS_SVH
`define SERIRQ_CONSTS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define SIRQ_RUN_WIDTH 4
`define SIRQ_FRAME_WIDTH 6
`define SIRQ_SOURCE_COUNT 21

// ----------------------------------------------------------------
// pulse widths in link clocks
// ----------------------------------------------------------------
`define SIRQ_START_MIN 4'h4
`define SIRQ_START_MAX 4'h8
`define SIRQ_STOP_QUIET 4'h2
`define SIRQ_STOP_CONT 4'h3

// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define SIRQ_LAST_FRAME 6'h20
`define SIRQ_LAST_SOURCE_FRAME 6'h15
`define SIRQ_IOCHCK_FRAME 6'h11
`define SIRQ_FIRST_SAMPLE 7'h02
`define SIRQ_FRAME_CLOCKS 7'h03
`define SIRQ_IOCHCK_SAMPLE 7'h32
`define SIRQ_LAST_SAMPLE 7'h5F

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SIRQ_QUIET_RESET 1'h0

`endif

// *** hdl/serirq_pkg.sv ***
package serirq_pkg;

    // ----------------------------------------------------------------
    // link states and frame phases
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_FRAMES = 2'b01,
        ST_STOP = 2'b10
    } link_state_e;

    typedef enum logic [1:0] {
        PH_TURN = 2'b00,
        PH_SAMPLE = 2'b01,
        PH_RECOV = 2'b10
    } frame_phase_e;

    // ----------------------------------------------------------------
    // carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] pciInt;
        logic iochck;
        logic [15:3] isaIrqHigh;
        logic smi;
        logic [1:0] isaIrqLow;
    } irq_sources_s;

    typedef struct packed {
        logic quietMode;
        logic cycleActive;
    } link_status_s;

endpackage : serirq_pkg

// *** hdl/level_sync.sv ***
`timescale 1ns/1ps

module level_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset of the receiving domain
    input wire logic clk,
    input wire logic reset,
    // levels
    input wire logic [WIDTH-1:0] levelIn,
    output logic [WIDTH-1:0] levelOut
);

    logic [WIDTH-1:0] stage1_q;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            stage1_q <= '0;
            levelOut <= '0;
        end else begin
            stage1_q <= levelIn;
            levelOut <= stage1_q;
        end
    end

endmodule : level_sync

// *** hdl/low_run_meter.sv ***
`timescale 1ns/1ps

module low_run_meter #(
    parameter int WIDTH = 4
) (
    // link clock and reset
    input wire logic clk,
    input wire logic reset,
    // line level
    input wire logic lineLow,
    // run measurement
    output logic [WIDTH-1:0] runLength,
    output logic riseSeen,
    output logic [WIDTH-1:0] riseWidth
);

    // counts consecutive low clocks, saturating
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            runLength <= '0;
        end else if (!lineLow) begin
            runLength <= '0;
        end else if (runLength != '1) begin
            runLength <= runLength + 1'b1;
        end
    end

    assign riseSeen = !lineLow && (runLength != '0);
    assign riseWidth = runLength;

endmodule : low_run_meter

// *** hdl/serial_irq_peripheral_link.sv ***
`timescale 1ns/1ps
`include "serirq_consts.svh"

// Overview of operation
// - line is shared open drain on the link clock; we pull low, drive high in recovery, or release
// - a cycle is one start frame, IRQ/Data frames, then one stop frame
// - start low pulse is accepted only when 4 to 8 clocks wide
// - in Quiet mode we may pull low one clock to request a start
// - after reset we sit idle in Continuous mode awaiting the host
// - frame counting begins at the rising edge ending the start pulse
// - each frame is three clocks: sample, recovery, turn-around
// - in sample phase of our frame pull low if source active, else release
// - drive high in recovery of our frames, release in turn-around
// - frame order fixed; frame 1 at 2 clocks, 3 clocks per frame
// - frames 22 to 32 carry nothing from us; last sample at 95
// - 2-clock stop selects Quiet, 3-clock stop selects Continuous
// - idle clocks after stop tolerated; next start may follow at once

module serial_irq_peripheral_link (
    // system side
    input wire logic clk,
    input wire logic reset,
    input serirq_pkg::irq_sources_s irqSources,
    output serirq_pkg::link_status_s linkStatus,
    // link side
    input wire logic pciClk,
    input wire logic serialIntLineIn,
    output logic serialIntLineOut,
    output logic serialIntLineOe
);

    import serirq_pkg::*;

    localparam int NSRC = `SIRQ_SOURCE_COUNT;
    localparam int RW = `SIRQ_RUN_WIDTH;
    localparam int FW = `SIRQ_FRAME_WIDTH;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // frame order: IRQ0, IRQ1, SMI, IRQ3..15, IOCHCK, INTA..INTD
    function automatic logic [NSRC-1:0] frameVector(input irq_sources_s s);
        frameVector = {s.pciInt, s.iochck, s.isaIrqHigh, s.smi, s.isaIrqLow};
    endfunction : frameVector

    function automatic logic ownFrame(input logic [FW-1:0] frame);
        ownFrame = (frame != '0) && (frame <= `SIRQ_LAST_SOURCE_FRAME);
    endfunction : ownFrame

    function automatic logic frameDrives(input logic [FW-1:0] frame,
                                         input logic [NSRC-1:0] vec);
        logic [FW-1:0] idx;
        idx = frame - 1'b1;
        frameDrives = ownFrame(frame) && vec[idx[4:0]];
    endfunction : frameDrives

    // ----------------------------------------------------------------
    // system clock side
    // ----------------------------------------------------------------
    irq_sources_s srcClk_q;
    link_status_s statusLink;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            srcClk_q <= '0;
        end else begin
            srcClk_q <= irqSources;
        end
    end

    level_sync #(
        .WIDTH(2)
    ) statusSync (
        .clk(clk),
        .reset(reset),
        .levelIn(statusLink),
        .levelOut(linkStatus)
    );

    // ----------------------------------------------------------------
    // link clock reset and source crossing
    // ----------------------------------------------------------------
    logic [1:0] linkRstPipe_q;
    logic linkRst;
    logic [NSRC-1:0] srcLink;

    always_ff @(posedge pciClk or posedge reset) begin
        if (reset) begin
            linkRstPipe_q <= 2'h3;
        end else begin
            linkRstPipe_q <= {linkRstPipe_q[0], 1'b0};
        end
    end

    assign linkRst = linkRstPipe_q[1];

    level_sync #(
        .WIDTH(NSRC)
    ) sourceSync (
        .clk(pciClk),
        .reset(linkRst),
        .levelIn(frameVector(srcClk_q)),
        .levelOut(srcLink)
    );

    // ----------------------------------------------------------------
    // line measurement
    // ----------------------------------------------------------------
    logic lineLow;
    logic [RW-1:0] runLength;
    logic riseSeen;
    logic [RW-1:0] riseWidth;

    assign lineLow = !serialIntLineIn;

    low_run_meter #(
        .WIDTH(RW)
    ) runMeter (
        .clk(pciClk),
        .reset(linkRst),
        .lineLow(lineLow),
        .runLength(runLength),
        .riseSeen(riseSeen),
        .riseWidth(riseWidth)
    );

    // ----------------------------------------------------------------
    // cycle sequencing
    // ----------------------------------------------------------------
    link_state_e state_q, state_d;
    frame_phase_e phase_q, phase_d;
    logic [FW-1:0] frame_q, frame_d;
    logic quiet_q, quiet_d;
    logic startOk;
    logic stopBegin;

    assign startOk = riseSeen && (riseWidth >= `SIRQ_START_MIN)
                     && (riseWidth <= `SIRQ_START_MAX);
    assign stopBegin = lineLow && (runLength >= (`SIRQ_STOP_QUIET - 4'h1));

    always_comb begin
        state_d = state_q;
        phase_d = phase_q;
        frame_d = frame_q;
        quiet_d = quiet_q;
        case (state_q)
            ST_IDLE: begin
                if (startOk) begin
                    state_d = ST_FRAMES;
                    phase_d = PH_TURN;
                    frame_d = '0;
                end
            end
            ST_FRAMES: begin
                if (stopBegin) begin
                    state_d = ST_STOP;
                end else begin
                    case (phase_q)
                        PH_TURN: begin
                            if (frame_q == `SIRQ_LAST_FRAME) begin
                                state_d = ST_STOP;
                            end else begin
                                phase_d = PH_SAMPLE;
                                frame_d = frame_q + 1'b1;
                            end
                        end
                        PH_SAMPLE: begin
                            phase_d = PH_RECOV;
                        end
                        PH_RECOV: begin
                            phase_d = PH_TURN;
                        end
                        default: begin
                            phase_d = PH_TURN;
                        end
                    endcase
                end
            end
            ST_STOP: begin
                if (riseSeen && (riseWidth >= `SIRQ_STOP_QUIET)) begin
                    state_d = ST_IDLE;
                    quiet_d = (riseWidth == `SIRQ_STOP_QUIET);
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pciClk or posedge linkRst) begin
        if (linkRst) begin
            state_q <= ST_IDLE;
            phase_q <= PH_TURN;
            frame_q <= '0;
        end else begin
            state_q <= state_d;
            phase_q <= phase_d;
            frame_q <= frame_d;
        end
    end

    always_ff @(posedge pciClk or posedge linkRst) begin
        if (linkRst) begin
            quiet_q <= `SIRQ_QUIET_RESET;
        end else begin
            quiet_q <= quiet_d;
        end
    end

    // ----------------------------------------------------------------
    // last states sent
    // ----------------------------------------------------------------
    logic [NSRC-1:0] sent_q;
    logic [FW-1:0] sentIdx;

    assign sentIdx = frame_d - 1'b1;

    always_ff @(posedge pciClk or posedge linkRst) begin
        if (linkRst) begin
            sent_q <= '0;
        end else if (state_d == ST_FRAMES && phase_d == PH_SAMPLE && ownFrame(frame_d)) begin
            sent_q[sentIdx[4:0]] <= srcLink[sentIdx[4:0]];
        end
    end

    // ----------------------------------------------------------------
    // line drive
    // ----------------------------------------------------------------
    logic kick;
    logic oe_d, out_d;

    assign kick = (state_q == ST_IDLE) && quiet_q && !lineLow && (runLength == '0)
                  && !serialIntLineOe && (srcLink != sent_q);

    always_comb begin
        oe_d = 1'b0;
        out_d = 1'b1;
        if (state_d == ST_FRAMES && ownFrame(frame_d)) begin
            if (phase_d == PH_SAMPLE && frameDrives(frame_d, srcLink)) begin
                oe_d = 1'b1;
                out_d = 1'b0;
            end else if (phase_d == PH_RECOV) begin
                oe_d = 1'b1;
                out_d = 1'b1;
            end
        end else if (kick) begin
            oe_d = 1'b1;
            out_d = 1'b0;
        end
    end

    always_ff @(posedge pciClk or posedge linkRst) begin
        if (linkRst) begin
            serialIntLineOe <= 1'b0;
            serialIntLineOut <= 1'b1;
        end else begin
            serialIntLineOe <= oe_d;
            serialIntLineOut <= out_d;
        end
    end

    assign statusLink = '{quietMode: quiet_q, cycleActive: (state_q != ST_IDLE)};

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic [6:0] sinceStart_q;

    always_ff @(posedge pciClk or posedge linkRst) begin
        if (linkRst) begin
            sinceStart_q <= '0;
        end else if (state_q == ST_IDLE && startOk) begin
            sinceStart_q <= 7'h01;
        end else if (state_q == ST_FRAMES && sinceStart_q != 7'h7F) begin
            sinceStart_q <= sinceStart_q + 7'h01;
        end
    end

    AST_SAMPLE_TIMING: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_FRAMES && phase_q == PH_SAMPLE)
        |-> (sinceStart_q == (`SIRQ_FRAME_CLOCKS * {1'b0, frame_q}) - 7'h01)
    ) else $error("frame sample point off its clock slot");

    AST_FIRST_SAMPLE: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_IDLE && startOk)
        |=> (phase_q == PH_TURN) ##1 (phase_q == PH_SAMPLE && frame_q == 6'h01
        && sinceStart_q == `SIRQ_FIRST_SAMPLE)
    ) else $error("first frame not sampled two clocks after start");

    AST_IOCHCK_AND_LAST: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_FRAMES && phase_q == PH_SAMPLE)
        |-> ((frame_q == `SIRQ_IOCHCK_FRAME) == (sinceStart_q == `SIRQ_IOCHCK_SAMPLE))
        && ((frame_q == `SIRQ_LAST_FRAME) == (sinceStart_q == `SIRQ_LAST_SAMPLE))
    ) else $error("frame 17 or frame 32 sample point wrong");

    AST_PHASE_ORDER: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_FRAMES && phase_q == PH_SAMPLE && !stopBegin)
        |=> (phase_q == PH_RECOV) ##1 (phase_q == PH_TURN || state_q == ST_STOP)
    ) else $error("frame phases out of order");

    AST_LOW_ONLY_IN_SAMPLE: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (serialIntLineOe && !serialIntLineOut)
        |-> (state_q == ST_FRAMES && phase_q == PH_SAMPLE && frameDrives(frame_q, sent_q))
        || (state_q == ST_IDLE && quiet_q)
    ) else $error("line pulled low outside a sample of an active source");

    AST_RECOVERY_THEN_RELEASE: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_FRAMES && phase_q == PH_SAMPLE && serialIntLineOe && !stopBegin)
        |=> (serialIntLineOe && serialIntLineOut) ##1 !serialIntLineOe
    ) else $error("recovery high or turn-around release missing");

    AST_NO_UNASSIGNED: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_FRAMES && frame_q > `SIRQ_LAST_SOURCE_FRAME) |-> !serialIntLineOe
    ) else $error("line driven in an unassigned frame");

    AST_KICK_ONE_CLOCK: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_IDLE && serialIntLineOe) |=> !serialIntLineOe
    ) else $error("start request held longer than one clock");

    AST_CONT_NO_KICK: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_IDLE && !quiet_q) |-> !serialIntLineOe
    ) else $error("start frame initiated in Continuous mode");

    AST_RESET_CONTINUOUS: assert property (
        @(posedge pciClk) disable iff (linkRst)
        $fell(linkRstPipe_q[1]) |-> (!quiet_q && state_q == ST_IDLE && !serialIntLineOe)
    ) else $error("not idle in Continuous mode after reset");

    AST_STOP_MODE: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_STOP && riseSeen && riseWidth >= `SIRQ_STOP_QUIET)
        |=> (quiet_q == ($past(riseWidth) == `SIRQ_STOP_QUIET)) && state_q == ST_IDLE
    ) else $error("stop width did not select the mode");

    AST_START_WIDTH: assert property (
        @(posedge pciClk) disable iff (linkRst)
        (state_q == ST_IDLE && riseSeen && riseWidth < `SIRQ_START_MIN)
        |=> state_q == ST_IDLE
    ) else $error("short low pulse taken as a start");

endmodule : serial_irq_peripheral_link

// *** tb/serirq_host_model.sv ***
`timescale 1ns/1ps

module serirq_host_model (
    // link clock and wired line
    input wire logic pciClk,
    input wire logic lineLevel,
    // view of the peripheral drivers
    input wire logic probeOe,
    input wire logic probeOut,
    // host drivers
    output logic hostOe,
    output logic hostOut,
    // per-frame report
    output logic frameStrobe,
    output logic [2:0] frameSeen,
    output logic kickSeen
);
    // ----------------------------------------------------------------
    // idle: line released, pull-up holds it high
    // ----------------------------------------------------------------
    initial begin
        hostOe = 1'b0;
        hostOut = 1'b1;
        frameStrobe = 1'b0;
        frameSeen = 3'h0;
        kickSeen = 1'b0;
    end

    task automatic step();
        @(posedge pciClk);
        #2;
    endtask : step

    // ----------------------------------------------------------------
    // low for n clocks, high for one, then release
    // ----------------------------------------------------------------
    task automatic pulse(input int n);
        hostOe = 1'b1;
        hostOut = 1'b0;
        repeat (n) step();
        hostOut = 1'b1;
        step();
        hostOe = 1'b0;
    endtask : pulse

    // ----------------------------------------------------------------
    // frames 1..nf: sample, recovery, turn-around
    // ----------------------------------------------------------------
    task automatic frames(input int nf);
        logic [2:0] acc;
        acc = 3'h0;
        for (int k = 1; k <= 3 * nf + 1; k++) begin
            #3;
            if (k % 3 == 2) acc[2] = ~lineLevel;
            if (k % 3 == 0) acc[1] = probeOe & probeOut;
            if (k % 3 == 1 && k > 1) begin
                acc[0] = probeOe;
                frameSeen = acc;
                frameStrobe = 1'b1;
            end
            step();
            frameStrobe = 1'b0;
        end
    endtask : frames

    // ----------------------------------------------------------------
    // one cycle, started by the host or on a peripheral kick
    // ----------------------------------------------------------------
    // aligned: start right after the stop's turn-around clock
    task automatic runCycle(input int lowW, input int stopW, input bit waitKick,
                            input bit aligned, input int nf);
        int t;
        t = 0;
        step();
        if (!aligned) step();
        if (waitKick) begin
            #3;
            while (lineLevel === 1'b1 && t < 300) begin
                step();
                #3;
                t++;
            end
            kickSeen = ~lineLevel;
            step();
        end
        pulse(lowW);
        frames(nf);
        pulse(stopW);
    endtask : runCycle
endmodule : serirq_host_model

// *** tb/tb_serial_irq_peripheral_link.sv ***
`timescale 1ns/1ps

module tb_serial_irq_peripheral_link;
    import serirq_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic clk;
    logic reset;
    logic pciClk;
    irq_sources_s irqSources;
    link_status_s linkStatus;
    logic devOut;
    logic devOe;
    logic hostOe;
    logic hostOut;
    logic lineLevel;
    logic frameStrobe;
    logic [2:0] frameSeen;
    logic kickSeen;
    logic [2:0] expQ[$];
    int n_mismatch = 0;
    int compares = 0;
    int seed = 32'hfe85;
    int oeCycles = 0;
    int badW[2] = '{3, 9};

    // ----------------------------------------------------------------
    // clocks and wired-and line with pull-up
    // ----------------------------------------------------------------
    always #50 clk = ~clk;
    initial begin
        pciClk = 1'b0;
        #13;
        forever #40 pciClk = ~pciClk;
    end
    assign lineLevel = ~((devOe & ~devOut) | (hostOe & ~hostOut));
    always @(posedge pciClk) if (devOe === 1'b1) oeCycles <= oeCycles + 1;

    serial_irq_peripheral_link serial_irq_peripheral_link_inst (
        .clk(clk),
        .reset(reset),
        .irqSources(irqSources),
        .linkStatus(linkStatus),
        .pciClk(pciClk),
        .serialIntLineIn(lineLevel),
        .serialIntLineOut(devOut),
        .serialIntLineOe(devOe)
    );

    serirq_host_model serirq_host_model_inst (
        .pciClk(pciClk),
        .lineLevel(lineLevel),
        .probeOe(devOe),
        .probeOut(devOut),
        .hostOe(hostOe),
        .hostOut(hostOut),
        .frameStrobe(frameStrobe),
        .frameSeen(frameSeen),
        .kickSeen(kickSeen)
    );

    // ----------------------------------------------------------------
    // checking helpers
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    // frame f: {pulled low, driven high in recovery, driven in turn-around}
    task automatic expectCycle(input logic [20:0] vec, input int nf);
        for (int f = 1; f <= nf; f++)
            expQ.push_back(f <= 21 ? {vec[f-1], 2'b10} : 3'b000);
    endtask : expectCycle

    task automatic quietLine(input string what, input int n);
        int base;
        base = oeCycles;
        repeat (n) @(posedge pciClk);
        #2;
        check(what, 8'(oeCycles - base), 8'h0);
    endtask : quietLine

    task automatic hostCycle(input int lowW, input int stopW, input bit kick, input bit aligned,
                             input int nf);
        expectCycle(irqSources, nf);
        serirq_host_model_inst.runCycle(lowW, stopW, kick, aligned, nf);
        repeat (4) @(posedge clk);
        #2;
        check("quiet mode", {7'h0, linkStatus.quietMode}, 8'(stopW == 2));
        check("cycle active", {7'h0, linkStatus.cycleActive}, 8'h0);
    endtask : hostCycle

    task automatic newSources(input logic [20:0] v);
        @(posedge clk);
        #2;
        irqSources = v;
    endtask : newSources

    // ----------------------------------------------------------------
    // frame monitor
    // ----------------------------------------------------------------
    always @(posedge frameStrobe) begin
        check("cycle active in frames", {7'h0, linkStatus.cycleActive}, 8'h1);
        if (expQ.size() == 0)
            check("unexpected frame", {5'h0, frameSeen}, 8'hFF);
        else
            check("frame", {5'h0, frameSeen}, {5'h0, expQ.pop_front()});
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        reset = 1'b1;
        irqSources = irq_sources_s'(21'($random(seed)));
        repeat (12) @(posedge clk);
        #2;
        reset = 1'b0;
        quietLine("drive after reset", 40);
        check("mode after reset", {7'h0, linkStatus.quietMode}, 8'h0);
        hostCycle(4, 3, 1'b0, 1'b0, 32);
        for (int i = 0; i < 5; i++) begin
            newSources(21'($random(seed)));
            quietLine("continuous kick", 8);
            hostCycle(4 + i, 3, 1'b0, 1'b0, i == 2 ? 17 : 32);
        end
        foreach (badW[j]) begin
            serirq_host_model_inst.step();
            serirq_host_model_inst.pulse(badW[j]);
            quietLine("odd start width", 120);
        end
        expectCycle(irqSources, 32);
        serirq_host_model_inst.runCycle(8, 3, 1'b0, 1'b0, 32);
        hostCycle(4, 2, 1'b0, 1'b1, 32);
        quietLine("unchanged sources", 20);
        for (int j = 0; j < 2; j++) begin
            newSources(irqSources ^ 21'(1 << (j * 20)));
            hostCycle(3 + j * 4, j == 0 ? 2 : 3, 1'b1, 1'b0, 32);
            check("kick", {7'h0, kickSeen}, 8'h1);
        end
        repeat (10) @(posedge clk);
        check("frames left", 8'(expQ.size()), 8'h0);
        give_verdict();
    end

    // ----------------------------------------------------------------
    // watchdog
    // ----------------------------------------------------------------
    initial begin
        #1_000_000;
        n_mismatch++;
        give_verdict();
    end
endmodule : tb_serial_irq_peripheral_link
